// *** logic/scf_fifo_irq.sv ***
// fifos, watermark and dma requests, unit resets and status of the serial codec port
// assumes serial timing comes from a framing block as one-cycle strobes on this clock
`timescale 1ns/1ps
module scf_fifo_irq
    import scf_pkg::*;
#(
    parameter int DATA_W = SCF_DATA_W,
    parameter int DEPTH  = SCF_DEPTH
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clock_enable,
    input  wire logic        module_stop,
    input  wire scf_bus_t    bus,
    output logic [31:0]      read_data,
    input  wire logic        tx_slot_pulse,
    output logic [31:0]      tx_word,
    input  wire logic        rx_word_valid,
    input  wire logic [31:0] rx_word,
    input  wire logic        ctrl_slot_pulse,
    input  wire logic [31:0] rx_ctrl_word,
    output logic [31:0]      ctrl_tx_word,
    output logic             ctrl_slot_enable,
    input  wire logic        bit_tick,
    input  wire logic        frame_sync_in,
    output logic             irq,
    output logic             tx_dma_request,
    output logic             rx_dma_request
);
    // pointers and counts are sized for exactly sixteen 32-bit words
    if (DEPTH != SCF_DEPTH || DATA_W != SCF_DATA_W) begin : g_bad_geometry
        $error("fifo geometry is fixed at sixteen words of 32 bits");
    end

    localparam logic [4:0] FULL = 5'h10;

    function automatic logic [4:0] tx_thr(input logic [2:0] c);
        case (c)
            WM_C100: tx_thr = 5'h0C;
            WM_C101: tx_thr = 5'h08;
            WM_C110: tx_thr = 5'h04;
            WM_C111: tx_thr = 5'h01;
            default: tx_thr = 5'h10;
        endcase
    endfunction

    function automatic logic [4:0] rx_thr(input logic [2:0] c);
        case (c)
            WM_C100: rx_thr = 5'h04;
            WM_C101: rx_thr = 5'h08;
            WM_C110: rx_thr = 5'h0C;
            WM_C111: rx_thr = 5'h10;
            default: rx_thr = 5'h01;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] control_reg;
    logic [5:0]  fifo_control_reg;
    logic [11:0] irq_enable_reg;
    logic [17:0] slot_reg;
    logic [5:0]  err_reg;
    logic        tx_ctrl_ready_reg;
    logic        rx_ctrl_ready_reg;
    logic [31:0] ctx_reg;
    logic [31:0] crx_reg;
    logic [31:0] rx_data_reg;
    logic [31:0] read_data_reg;
    logic        tx_gap_reg;
    logic        rx_gap_reg;
    logic [7:0]  bit_cnt_reg;
    logic        framed_reg;

    logic [31:0] tx_mem [DEPTH];
    logic [31:0] rx_mem [DEPTH];
    logic [3:0]  tx_wp_reg;
    logic [3:0]  tx_rp_reg;
    logic [3:0]  rx_wp_reg;
    logic [3:0]  rx_rp_reg;
    logic [4:0]  tx_cnt_reg;
    logic [4:0]  rx_cnt_reg;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire run       = ~module_stop;
    wire tx_en     = control_reg[CTL_TXE];
    wire rx_en     = control_reg[CTL_RXE];
    wire wr_ctrl   = bus.wr && bus.addr == ADR_CTRL;
    wire tx_rst    = wr_ctrl && bus.wdata[CTL_TX_UNIT_RESET];
    wire rx_rst    = wr_ctrl && bus.wdata[CTL_RX_UNIT_RESET];
    wire wr_stat   = bus.wr && bus.addr == ADR_STAT;
    wire tx_full   = tx_cnt_reg == FULL;
    wire tx_empty  = tx_cnt_reg == 5'h00;
    wire rx_full   = rx_cnt_reg == FULL;
    wire rx_empty  = rx_cnt_reg == 5'h00;

    wire tx_push_try = bus.wr && bus.addr == ADR_TXD;
    wire tx_push     = tx_push_try && !tx_full;
    wire tx_ov_set   = tx_push_try && tx_full;
    wire tx_pop_try  = run && tx_en && tx_slot_pulse;
    wire tx_pop      = tx_pop_try && !tx_empty;
    wire tx_uf_set   = tx_pop_try && tx_empty;
    wire rx_push_try = run && rx_en && rx_word_valid;
    wire rx_push     = rx_push_try && !rx_full;
    wire rx_ov_set   = rx_push_try && rx_full;
    wire rx_pop_try  = bus.rd && bus.addr == ADR_RXD;
    wire rx_pop      = rx_pop_try && !rx_empty;
    wire rx_uf_set   = rx_pop_try && rx_empty;

    wire [4:0] tx_free = FULL - tx_cnt_reg;
    wire tx_req = tx_en && tx_free >= tx_thr(fifo_control_reg[5:3]);
    wire rx_req = rx_en && rx_cnt_reg >= rx_thr(fifo_control_reg[2:0]);

    // an enabled control slot equal to a data slot turns the whole control channel off and sets an error
    wire c0_hit = slot_reg[SL_C0E] && (slot_reg[SL_CD0 +: 4] == slot_reg[SL_TX +: 4]
                  || slot_reg[SL_CD0 +: 4] == slot_reg[SL_RX +: 4]);
    wire c1_hit = slot_reg[SL_C1E] && (slot_reg[SL_CD1 +: 4] == slot_reg[SL_TX +: 4]
                  || slot_reg[SL_CD1 +: 4] == slot_reg[SL_RX +: 4]);
    wire slot_conflict = c0_hit || c1_hit;
    wire ctl_on  = control_reg[CTL_SLOT16] && (slot_reg[SL_C0E] || slot_reg[SL_C1E]) && !slot_conflict;
    wire ctl_go  = run && ctl_on && ctrl_slot_pulse;

    wire [7:0] flen_m1   = control_reg[CTL_FLEN +: 8];
    wire       tick      = run && bit_tick;
    wire       sync_early = tick && frame_sync_in && control_reg[CTL_SLAVE]
                            && framed_reg && bit_cnt_reg != flen_m1;

    wire [5:0] err_set = {slot_conflict, sync_early, rx_uf_set, rx_ov_set, tx_ov_set, tx_uf_set};
    wire [5:0] err_clr = wr_stat ? bus.wdata[ST_RXUF + 2 : ST_TXUF] : 6'h00;

    wire [11:0] status = {err_reg, rx_ctrl_ready_reg, tx_ctrl_ready_reg,
                          rx_full, rx_req, tx_en && tx_empty, tx_req};
    wire tx_dma_en = control_reg[CTL_TDMA];
    wire rx_dma_en = control_reg[CTL_RDMA];

    assign irq            = |(status & irq_enable_reg);
    assign tx_dma_request = tx_dma_en && tx_req && !tx_gap_reg;
    assign rx_dma_request = rx_dma_en && rx_req && !rx_gap_reg;
    assign ctrl_slot_enable = ctl_on;
    assign read_data      = read_data_reg;

    logic [31:0] rd_mux;
    always_comb begin
        case (bus.addr)
            ADR_CTRL: rd_mux = control_reg & ~(32'h1 << CTL_TX_UNIT_RESET | 32'h1 << CTL_RX_UNIT_RESET);
            ADR_FIFO: rd_mux = {fifo_control_reg[5:3], tx_free, 8'h00,
                                fifo_control_reg[2:0], rx_cnt_reg, 8'h00};
            ADR_STAT: rd_mux = {20'h00000, status};
            ADR_IEN:  rd_mux = {20'h00000, irq_enable_reg};
            ADR_RXD:  rd_mux = rx_empty ? rx_data_reg : rx_mem[rx_rp_reg];
            ADR_CRX:  rd_mux = crx_reg;
            ADR_SLOT: rd_mux = {14'h0000, slot_reg};
            default:  rd_mux = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // host registers
    always_ff @(posedge clock) begin
        if (reset) begin
            control_reg      <= CTRL_RST;
            fifo_control_reg <= 6'h00;
            irq_enable_reg   <= IEN_RST[11:0];
            slot_reg         <= SLOT_RST[17:0];
            read_data_reg    <= 32'h00000000;
        end else if (clock_enable) begin
            read_data_reg <= bus.rd ? rd_mux : 32'h00000000;
            if (wr_ctrl) begin
                control_reg <= bus.wdata;
                control_reg[CTL_TX_UNIT_RESET] <= 1'b0;
                control_reg[CTL_RX_UNIT_RESET] <= 1'b0;
                if (bus.wdata[CTL_TX_UNIT_RESET])
                    control_reg[CTL_TXE] <= 1'b0;
                if (bus.wdata[CTL_RX_UNIT_RESET])
                    control_reg[CTL_RXE] <= 1'b0;
            end
            if (bus.wr && bus.addr == ADR_FIFO)
                fifo_control_reg <= {bus.wdata[FC_TWM +: 3], bus.wdata[FC_RWM +: 3]};
            if (bus.wr && bus.addr == ADR_IEN)
                irq_enable_reg <= bus.wdata[11:0];
            if (bus.wr && bus.addr == ADR_SLOT)
                slot_reg <= bus.wdata[17:0];
        end
    end

    // error flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge clock) begin
        if (reset)
            err_reg <= 6'h00;
        else if (clock_enable)
            err_reg <= (err_reg & ~err_clr) | err_set;
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit fifo
    always_ff @(posedge clock) begin
        if (tx_push && clock_enable)
            tx_mem[tx_wp_reg] <= bus.wdata;
    end

    always_ff @(posedge clock) begin
        if (reset || (clock_enable && tx_rst)) begin
            tx_wp_reg  <= 4'h0;
            tx_rp_reg  <= 4'h0;
            tx_cnt_reg <= 5'h00;
            tx_word    <= 32'h00000000;
        end else if (clock_enable) begin
            if (tx_push)
                tx_wp_reg <= tx_wp_reg + 4'h1;
            if (tx_pop) begin
                tx_rp_reg <= tx_rp_reg + 4'h1;
                tx_word   <= tx_mem[tx_rp_reg];
            end
            tx_cnt_reg <= tx_cnt_reg + {4'h0, tx_push} - {4'h0, tx_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive fifo
    always_ff @(posedge clock) begin
        if (rx_push && clock_enable)
            rx_mem[rx_wp_reg] <= rx_word;
    end

    always_ff @(posedge clock) begin
        if (reset || (clock_enable && rx_rst)) begin
            rx_wp_reg   <= 4'h0;
            rx_rp_reg   <= 4'h0;
            rx_cnt_reg  <= 5'h00;
            rx_data_reg <= 32'h00000000;
        end else if (clock_enable) begin
            if (rx_push)
                rx_wp_reg <= rx_wp_reg + 4'h1;
            if (rx_pop) begin
                rx_rp_reg   <= rx_rp_reg + 4'h1;
                rx_data_reg <= rx_mem[rx_rp_reg];
            end
            rx_cnt_reg <= rx_cnt_reg + {4'h0, rx_push} - {4'h0, rx_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dma gaps: request held low for the cycle after each dma data access
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_gap_reg <= 1'b0;
            rx_gap_reg <= 1'b0;
        end else if (clock_enable) begin
            tx_gap_reg <= tx_dma_en && tx_push;
            rx_gap_reg <= rx_dma_en && rx_pop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control data channel
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_ctrl_ready_reg    <= 1'b0;
            rx_ctrl_ready_reg    <= 1'b0;
            ctx_reg      <= 32'h00000000;
            crx_reg      <= 32'h00000000;
            ctrl_tx_word <= 32'h00000000;
        end else if (clock_enable) begin
            if (bus.wr && bus.addr == ADR_CTX) begin
                ctx_reg   <= bus.wdata;
                tx_ctrl_ready_reg <= 1'b0;
            end
            if (bus.rd && bus.addr == ADR_CRX)
                rx_ctrl_ready_reg <= 1'b0;
            if (ctl_go) begin
                ctrl_tx_word <= ctx_reg;
                crx_reg      <= rx_ctrl_word;
                tx_ctrl_ready_reg    <= 1'b1;
                rx_ctrl_ready_reg    <= 1'b1;
            end
            if (tx_rst)
                tx_ctrl_ready_reg <= 1'b0;
            if (rx_rst)
                rx_ctrl_ready_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame bit counter, restarted by every sync
    always_ff @(posedge clock) begin
        if (reset) begin
            bit_cnt_reg <= 8'h00;
            framed_reg  <= 1'b0;
        end else if (clock_enable && tick) begin
            if (frame_sync_in) begin
                bit_cnt_reg <= 8'h00;
                framed_reg  <= 1'b1;
            end else if (bit_cnt_reg == flen_m1)
                bit_cnt_reg <= 8'h00;
            else
                bit_cnt_reg <= bit_cnt_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_dma_push;
        clock_enable && tx_dma_en && tx_push && !tx_rst;
    endsequence

    // a frozen cycle or a back-to-back push may keep the gap one cycle longer
    sequence s_gap_then_back;
        !tx_dma_request ##1 (!tx_gap_reg || $past(!clock_enable || tx_push));
    endsequence

    chk_tx_overflow_drop: assert property (clock_enable && tx_ov_set && !tx_rst && !tx_pop
        |=> err_reg[1] && tx_cnt_reg == FULL) else $error("tx overflow not dropped");
    chk_rx_overflow_lost: assert property (clock_enable && rx_ov_set && !rx_rst && !rx_pop
        |=> err_reg[2] && rx_cnt_reg == FULL) else $error("rx overflow not flagged");
    chk_tx_free_step: assert property (clock_enable && tx_push && !tx_pop && !tx_rst
        |=> tx_free == $past(tx_free) - 5'h01) else $error("tx free count wrong");
    chk_rx_fill_step: assert property (clock_enable && rx_push && !rx_pop && !rx_rst
        |=> rx_cnt_reg == $past(rx_cnt_reg) + 5'h01) else $error("rx fill count wrong");
    chk_tx_req_level: assert property (tx_en && fifo_control_reg[5:3] == WM_C111 && !tx_full
        |-> status[ST_TXREQ]) else $error("tx request missing");
    chk_rx_req_drop: assert property (fifo_control_reg[2:0] == WM_C000 && rx_empty
        |-> !status[ST_RXREQ]) else $error("rx request not withdrawn");
    chk_tx_reset_clear: assert property (clock_enable && tx_rst
        |=> tx_cnt_reg == 5'h00 && !tx_en && tx_word == 32'h00000000 && !tx_ctrl_ready_reg)
        else $error("tx reset incomplete");
    chk_rx_reset_clear: assert property (clock_enable && rx_rst
        |=> rx_cnt_reg == 5'h00 && !rx_en && rx_data_reg == 32'h00000000 && !rx_ctrl_ready_reg)
        else $error("rx reset incomplete");
    chk_dma_gap_pulse: assert property (s_dma_push |=> s_gap_then_back)
        else $error("dma request gap wrong");
    chk_underflow_resend: assert property (clock_enable && tx_uf_set && !tx_rst
        |=> err_reg[0] && $stable(tx_word)) else $error("tx underflow mishandled");
    chk_err_sticky_hold: assert property (clock_enable && err_reg[5] && !wr_stat
        |=> err_reg[5]) else $error("error flag lost");
    chk_irq_gate_out: assert property ((status & irq_enable_reg) == 12'h000
        |-> !irq) else $error("spurious interrupt");
endmodule

// *** include/scf_pkg.sv ***
// constants, field layout and bus carrier for the serial codec fifo and request block
// assumes one 20 MHz clock and a host that issues single-cycle strobes
package scf_pkg;
    localparam int SCF_DEPTH  = 16;
    localparam int SCF_DATA_W = 32;
    localparam int SCF_CNT_W  = 5;
    localparam int SCF_ADDR_W = 8;
    localparam int SCF_NSTAT  = 12;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_FIFO = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_IEN  = 8'h0C;
    localparam logic [7:0] ADR_TXD  = 8'h10;
    localparam logic [7:0] ADR_RXD  = 8'h14;
    localparam logic [7:0] ADR_CTX  = 8'h18;
    localparam logic [7:0] ADR_CRX  = 8'h1C;
    localparam logic [7:0] ADR_SLOT = 8'h20;

    // control_reg bits
    localparam int CTL_TXE    = 0;
    localparam int CTL_RXE    = 1;
    localparam int CTL_SLAVE  = 2;
    localparam int CTL_SLOT16 = 3;
    localparam int CTL_TDMA   = 4;
    localparam int CTL_RDMA   = 5;
    localparam int CTL_TX_UNIT_RESET  = 8;
    localparam int CTL_RX_UNIT_RESET  = 9;
    localparam int CTL_FLEN   = 16;
    localparam logic [31:0] CTRL_RST = 32'h001F0000;

    // fifo register fields, as bit positions in the bus word
    localparam int FC_TWM   = 29;
    localparam int FC_TFREE = 24;
    localparam int FC_RWM   = 13;
    localparam int FC_RFILL = 8;

    // slot register fields
    localparam int SL_TX  = 0;
    localparam int SL_RX  = 4;
    localparam int SL_CD0 = 8;
    localparam int SL_CD1 = 12;
    localparam int SL_C0E = 16;
    localparam int SL_C1E = 17;
    localparam logic [31:0] SLOT_RST = 32'h00000000;
    localparam logic [31:0] IEN_RST  = 32'h00000000;

    // status bit positions
    localparam int ST_TXREQ = 0;
    localparam int ST_TXEMP = 1;
    localparam int ST_RXREQ = 2;
    localparam int ST_RXFUL = 3;
    localparam int ST_TX_CTRL_READY = 4;
    localparam int ST_RX_CTRL_READY = 5;
    localparam int ST_TXUF  = 6;
    localparam int ST_TXOV  = 7;
    localparam int ST_RXOV  = 8;
    localparam int ST_RXUF  = 9;
    localparam int ST_SYNC  = 10;
    localparam int ST_SLOT  = 11;
    localparam logic [11:0] ST_ERR_MASK = 12'hFC0;

    localparam logic [2:0] WM_C000 = 3'h0;
    localparam logic [2:0] WM_C100 = 3'h4;
    localparam logic [2:0] WM_C101 = 3'h5;
    localparam logic [2:0] WM_C110 = 3'h6;
    localparam logic [2:0] WM_C111 = 3'h7;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } scf_bus_t;
endpackage

// *** verif/scf_serial_model.sv ***
// stand-in for the framing block: transmit slot strobes and received words
// assumes calls come from one bench process; each strobe lasts one clock
`timescale 1ns/1ps
module scf_serial_model (
    input  wire logic        clock,
    output logic             tx_slot_pulse,
    output logic             rx_word_valid,
    output logic [31:0]      rx_word,
    output logic             ctrl_slot_pulse,
    output logic [31:0]      rx_ctrl_word,
    output logic             bit_tick,
    output logic             frame_sync_in
);
    initial begin
        tx_slot_pulse   = 1'b0;
        rx_word_valid   = 1'b0;
        rx_word         = 32'h00000000;
        ctrl_slot_pulse = 1'b0;
        rx_ctrl_word    = 32'h00000000;
        bit_tick        = 1'b0;
        frame_sync_in   = 1'b0;
    end
    task automatic ctrl_slot(input logic [31:0] w);
        @(posedge clock);
        ctrl_slot_pulse <= 1'b1;
        rx_ctrl_word    <= w;
        @(posedge clock);
        ctrl_slot_pulse <= 1'b0;
        rx_ctrl_word    <= ~w;
    endtask
    // one serial bit; sync marks the first bit of a frame
    task automatic tick(input logic sync);
        @(posedge clock);
        bit_tick      <= 1'b1;
        frame_sync_in <= sync;
        @(posedge clock);
        bit_tick      <= 1'b0;
        frame_sync_in <= 1'b0;
    endtask
    task automatic slot();
        @(posedge clock);
        tx_slot_pulse <= 1'b1;
        @(posedge clock);
        tx_slot_pulse <= 1'b0;
    endtask
    task automatic push(input logic [31:0] w);
        @(posedge clock);
        rx_word_valid <= 1'b1;
        rx_word       <= w;
        @(posedge clock);
        rx_word_valid <= 1'b0;
        // inverted so a late sample cannot pass on a stale word
        rx_word       <= ~w;
    endtask
endmodule

// *** verif/tb_serial_codec_fifo_irq.sv ***
// self-checking bench for the fifo, request, reset and status block
// assumes the serial stand-in model and single-cycle host strobes
`timescale 1ns/1ps
module tb_serial_codec_fifo_irq
    import scf_pkg::*;
();
    logic        clock       = 1'b0;
    logic        clock_enable = 1'b1;
    logic [31:0] rx_ctrl_word, ctrl_tx_word;
    logic        ctrl_slot_pulse, ctrl_slot_enable, bit_tick, frame_sync_in;
    logic        reset       = 1'b1;
    logic        module_stop = 1'b0;
    scf_bus_t    bus         = '0;
    logic [31:0] read_data, tx_word, rx_word, v;
    logic        tx_slot_pulse, rx_word_valid, irq, tx_dma_request, rx_dma_request;
    int          mismatches  = 0;
    int          check_count = 0;
    always #25 clock = ~clock;
    scf_serial_model scf_serial_model_inst (.clock(clock), .tx_slot_pulse(tx_slot_pulse),
        .rx_word_valid(rx_word_valid), .rx_word(rx_word), .ctrl_slot_pulse(ctrl_slot_pulse),
        .rx_ctrl_word(rx_ctrl_word), .bit_tick(bit_tick), .frame_sync_in(frame_sync_in));
    scf_fifo_irq scf_fifo_irq_inst (.clock(clock), .reset(reset), .clock_enable(clock_enable),
        .module_stop(module_stop), .bus(bus), .read_data(read_data), .tx_slot_pulse(tx_slot_pulse),
        .tx_word(tx_word), .rx_word_valid(rx_word_valid), .rx_word(rx_word), .ctrl_slot_pulse(ctrl_slot_pulse),
        .rx_ctrl_word(rx_ctrl_word), .ctrl_tx_word(ctrl_tx_word), .ctrl_slot_enable(ctrl_slot_enable),
        .bit_tick(bit_tick), .frame_sync_in(frame_sync_in), .irq(irq), .tx_dma_request(tx_dma_request),
        .rx_dma_request(rx_dma_request));
////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] fl(input logic [31:0] w, input int lsb, input int n);
        return (w >> lsb) & ((32'h1 << n) - 1);
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 d = read_data;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(ADR_CTRL, v);
        chk("control", v, CTRL_RST);
        rd(ADR_FIFO, v);
        chk("tx free", fl(v, FC_TFREE, 5), 32'h10);
        chk("rx fill", fl(v, FC_RFILL, 5), 32'h0);
        rd(ADR_IEN, v);
        chk("irq enable", v, IEN_RST);
        rd(8'h40, v);
        chk("unmapped", v, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_tx();
        wr(ADR_IEN, 32'h00000080);
        wr(ADR_CTRL, CTRL_RST | 32'h1);
        wr(ADR_FIFO, {3'h5, 29'h0});
        rd(ADR_STAT, v);
        chk("tx empty", fl(v, ST_TXEMP, 1), 32'h1);
        for (int i = 0; i < 16; i++) begin
            wr(ADR_TXD, 32'hA5000000 + i);
            rd(ADR_FIFO, v);
            chk("tx free", fl(v, FC_TFREE, 5), 15 - i);
            rd(ADR_STAT, v);
            chk("tx req", fl(v, ST_TXREQ, 1), (15 - i) >= 8);
        end
        wr(ADR_TXD, 32'hDEAD0000);
        rd(ADR_STAT, v);
        chk("tx overflow", fl(v, ST_TXOV, 1), 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            scf_serial_model_inst.slot();
            #1 chk("tx word", tx_word, 32'hA5000000 + i);
        end
        scf_serial_model_inst.slot();
        #1 chk("tx resend", tx_word, 32'hA500000F);
        rd(ADR_STAT, v);
        chk("tx underflow", fl(v, ST_TXUF, 1), 32'h1);
        chk("tx ovf held", fl(v, ST_TXOV, 1), 32'h1);
        wr(ADR_STAT, 32'h000000C0);
        rd(ADR_STAT, v);
        chk("tx errors", fl(v, ST_TXUF, 2), 32'h0);
        chk("irq off", {31'h0, irq}, 32'h0);
        $display("test tx done");
    endtask
    task automatic t_rx();
        wr(ADR_CTRL, CTRL_RST | 32'h2);
        wr(ADR_FIFO, {16'h0, 3'h5, 13'h0});
        module_stop <= 1'b1;
        scf_serial_model_inst.push(32'h11111111);
        rd(ADR_FIFO, v);
        chk("fill in stop", fl(v, FC_RFILL, 5), 32'h0);
        rd(ADR_CTRL, v);
        chk("ctrl in stop", v, CTRL_RST | 32'h2);
        @(posedge clock);
        module_stop <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            scf_serial_model_inst.push(32'h5A000000 + i);
            rd(ADR_FIFO, v);
            chk("rx fill", fl(v, FC_RFILL, 5), i + 1);
            rd(ADR_STAT, v);
            chk("rx req", fl(v, ST_RXREQ, 1), (i + 1) >= 8);
        end
        scf_serial_model_inst.push(32'hBAD00000);
        rd(ADR_STAT, v);
        chk("rx full", fl(v, ST_RXFUL, 1), 32'h1);
        chk("rx overflow", fl(v, ST_RXOV, 1), 32'h1);
        for (int i = 0; i < 16; i++) begin
            rd(ADR_RXD, v);
            chk("rx word", v, 32'h5A000000 + i);
        end
        rd(ADR_RXD, v);
        rd(ADR_STAT, v);
        chk("rx underflow", fl(v, ST_RXUF, 1), 32'h1);
        chk("rx full gone", fl(v, ST_RXFUL, 1), 32'h0);
        $display("test rx done");
    endtask
    task automatic t_unit_reset();
        wr(ADR_CTRL, CTRL_RST | 32'h3);
        for (int i = 0; i < 3; i++)
            wr(ADR_TXD, 32'h00000100 + i);
        scf_serial_model_inst.push(32'h00000021);
        scf_serial_model_inst.push(32'h00000022);
        wr(ADR_CTRL, CTRL_RST | 32'h103);
        rd(ADR_FIFO, v);
        chk("tx free rst", fl(v, FC_TFREE, 5), 32'h10);
        chk("tx word rst", tx_word, 32'h00000000);
        chk("rx fill kept", fl(v, FC_RFILL, 5), 32'h2);
        rd(ADR_CTRL, v);
        chk("ctrl tx_unit_reset", v, CTRL_RST | 32'h2);
        wr(ADR_CTRL, CTRL_RST | 32'h203);
        rd(ADR_FIFO, v);
        chk("rx fill rst", fl(v, FC_RFILL, 5), 32'h0);
        rd(ADR_RXD, v);
        chk("rx data rst", v, 32'h00000000);
        rd(ADR_CTRL, v);
        chk("ctrl rx_unit_reset", v, CTRL_RST | 32'h1);
        $display("test unit reset done");
    endtask
    task automatic t_dma();
        wr(ADR_CTRL, CTRL_RST | 32'h33);
        wr(ADR_FIFO, {3'h7, 29'h0});
        #1 chk("tx dma", {31'h0, tx_dma_request}, 32'h1);
        wr(ADR_TXD, 32'h00000077);
        #1 chk("tx dma drop", {31'h0, tx_dma_request}, 32'h0);
        @(posedge clock);
        #1 chk("tx dma back", {31'h0, tx_dma_request}, 32'h1);
        scf_serial_model_inst.push(32'h00000031);
        scf_serial_model_inst.push(32'h00000032);
        #1 chk("rx dma", {31'h0, rx_dma_request}, 32'h1);
        rd(ADR_RXD, v);
        chk("rx dma drop", {31'h0, rx_dma_request}, 32'h0);
        @(posedge clock);
        #1 chk("rx dma back", {31'h0, rx_dma_request}, 32'h1);
        $display("test dma done");
    endtask
    task automatic t_ctrl();
        wr(ADR_CTRL, CTRL_RST | 32'h308);
        wr(ADR_SLOT, 32'h00010210);
        #1 chk("ctrl on", {31'h0, ctrl_slot_enable}, 32'h1);
        wr(ADR_CTX, 32'h0000C0DE);
        scf_serial_model_inst.ctrl_slot(32'h0000BEEF);
        #1 chk("ctrl tx word", ctrl_tx_word, 32'h0000C0DE);
        rd(ADR_STAT, v);
        chk("ctrl ready", fl(v, ST_TX_CTRL_READY, 2), 32'h3);
        rd(ADR_CRX, v);
        chk("ctrl rx word", v, 32'h0000BEEF);
        wr(ADR_CTRL, CTRL_RST);
        #1 chk("ctrl off 8 bit", {31'h0, ctrl_slot_enable}, 32'h0);
        wr(ADR_CTX, 32'h00001234);
        scf_serial_model_inst.ctrl_slot(32'h00005678);
        #1 chk("ctrl word kept", ctrl_tx_word, 32'h0000C0DE);
        rd(ADR_STAT, v);
        chk("ctrl ready 8 bit", fl(v, ST_TX_CTRL_READY, 2), 32'h0);
        wr(ADR_IEN, 32'h00000800);
        wr(ADR_CTRL, CTRL_RST | 32'h8);
        wr(ADR_SLOT, 32'h00010010);
        #1 chk("ctrl off shared", {31'h0, ctrl_slot_enable}, 32'h0);
        wr(ADR_SLOT, 32'h00010210);
        rd(ADR_STAT, v);
        chk("slot error held", fl(v, ST_SLOT, 1), 32'h1);
        chk("irq slot", {31'h0, irq}, 32'h1);
        wr(ADR_STAT, 32'h00000800);
        rd(ADR_STAT, v);
        chk("slot error clr", fl(v, ST_SLOT, 1), 32'h0);
        wr(ADR_CTRL, CTRL_RST | 32'h4);
        scf_serial_model_inst.tick(1'b1);
        repeat (2) scf_serial_model_inst.tick(1'b0);
        scf_serial_model_inst.tick(1'b1);
        rd(ADR_STAT, v);
        chk("sync early", fl(v, ST_SYNC, 1), 32'h1);
        wr(ADR_STAT, 32'h00000400);
        // a full frame counted from the early sync must be on time
        repeat (31) scf_serial_model_inst.tick(1'b0);
        scf_serial_model_inst.tick(1'b1);
        rd(ADR_STAT, v);
        chk("sync on time", fl(v, ST_SYNC, 1), 32'h0);
        clock_enable <= 1'b0;
        wr(ADR_TXD, 32'h00000055);
        clock_enable <= 1'b1;
        rd(ADR_FIFO, v);
        chk("frozen write", fl(v, FC_TFREE, 5), 32'h10);
        $display("test ctrl done");
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_unit_reset();
        t_dma();
        t_ctrl();
        final_report();
    end
    // all tests need well under a thousand cycles
    initial begin
        #(50 * 4000);
        mismatches++;
        final_report();
    end
endmodule
